//--- design/rcial_core.sv
// Function
// - Thirty-two 32-bit general registers feed one 32-bit ALU.
// - Register zero always reads zero, whatever writes name it.
// - Funnel shift selects 32 bits from the 64-bit pair by count N.
// - Memory-format addresses are base register plus sign-extended 17-bit offset.
// - Only words move; the upper 30 address bits go out.
// - Load/store offsets count bytes; branch and jump displacements count words.
// - Bit 0 is the most significant bit; byte 0 sits at that end.
// - Address top bit one means user space, zero means system space.
// - In user mode the top data address bit is forced to one.
// - System mode passes addresses unchanged.
// - Coprocessor transfers drive the offset field on the address lines.
// - Floating-point loads and stores show the register specifier on select lines.
// - Uncached load and store bypass the cache with normal addressing.
// - Six register compare branches, each also in a squashing form.
// - Condition in ALU while a separate adder forms the target together.
// - Byte rotate left by Src2 low two bits, or their complement.
// - Add-immediate adds sign-extended 17-bit immediate to source into destination.
// - Indexed jump-and-link saves next PC and jumps to source plus immediate.
// - Overflow and the trap instruction are the internal exceptions; a state bit masks overflow.
// - Maskable and nonmaskable interrupts are taken; every instruction can restart.
// - Mode lives in the state word; writes to it need system mode, but the restoring jump reloads it in either mode.
// - Multiply and divide only by single-bit steps with the muldiv register.
// - A not-taken squashing branch cancels both delay-slot instructions.
// - Branches and jumps take effect after two delay slots.
//
// Purpose: Decode, execute and address generation for a 32-bit load-store core.
// Assumes: instr_in holds the word fetched from fetch_pc_q one cycle earlier;
//          mem_rdata answers in the cycle a read request is shown.
// Notes: Results are written at the end of the execute cycle; load data one cycle later.
`timescale 1ns/1ns
module rcial_core
    import rcial_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [XLEN-1:0] instr_in,
    input wire logic [XLEN-1:0] mem_rdata,
    input wire logic irq_req,
    input wire logic nmi_req,
    output logic [WA_W-1:0] fetch_pc_q,
    output rcial_mem_req_t mem_req_q,
    output logic [PSW_W-1:0] psw_q,
    output logic exc_taken_q
);
    // Sign extension of the 17-bit offset, shared by addressing and add-immediate.
    function automatic logic [XLEN-1:0] sext_off(input logic [OFF_W-1:0] o);
        sext_off = {{(XLEN-OFF_W){o[OFF_W-1]}}, o};
    endfunction : sext_off

    // Byte rotate left; big-endian bits 30:31 are vector bits 1:0.
    function automatic logic [XLEN-1:0] rotl_bytes(input logic [XLEN-1:0] v,
                                                   input logic [1:0] n);
        logic [2*XLEN-1:0] dbl;
        dbl = {v, v} << {n, 3'h0};
        rotl_bytes = dbl[2*XLEN-1:XLEN];
    endfunction : rotl_bytes

    // Funnel shift: low N bits of the second source over top bits of the first.
    function automatic logic [XLEN-1:0] funnel(input logic [XLEN-1:0] a,
                                               input logic [XLEN-1:0] b,
                                               input logic [4:0] n);
        logic [2*XLEN-1:0] pair;
        pair = {b, a} >> n;
        funnel = pair[XLEN-1:0];
    endfunction : funnel

    rcial_stage_t exe_q;
    logic [WA_W-1:0] if_pc_q;
    logic kill_q;
    logic [PSW_W-1:0] psw_o_q;
    logic [XLEN-1:0] md_q;
    logic [WA_W-1:0] epc_q;
    logic ld_pend_q;
    logic [RS_W-1:0] ld_dst_q;
    logic irq_s1_q, irq_s2_q, nmi_s1_q, nmi_s2_q, nmi_s3_q, nmi_pend_q;

    rcial_class_t cls;
    logic [2:0] op;
    logic [RS_W-1:0] s1f, s2f, dsf;
    logic [3:0] fn;
    logic [4:0] shn;
    logic [OFF_W-1:0] off;
    logic [1:0] spr;
    logic [XLEN-1:0] rs1, rs2, res, md_d, addr_raw, addr_eff, addi_s, dv;
    logic [XLEN:0] add_w, sub_w, ms_w;
    logic [WA_W-1:0] br_tgt, jump_pc;
    logic add_ovf, sub_ovf, addi_ovf, ovf, wr_en, md_we, taken, jump, is_br;
    logic psw_wr, pswo_wr, epc_wr, restore, trap_ins, user;
    logic [RS_W-1:0] wr_dst;
    logic irq_take, exc, fire, squash, redirect, kill_now;

    // Field extraction from the instruction in the execute stage.
    assign cls = rcial_class_t'(exe_q.ins[F_CLS_HI:F_CLS_LO]);
    assign op = exe_q.ins[F_OP_HI:F_OP_LO];
    assign s1f = exe_q.ins[F_S1_HI:F_S1_LO];
    assign s2f = exe_q.ins[F_S2_HI:F_S2_LO];
    assign dsf = exe_q.ins[F_DS_HI:F_DS_LO];
    assign fn = exe_q.ins[F_FN_HI:F_FN_LO];
    assign shn = exe_q.ins[F_SH_HI:0];
    assign off = exe_q.ins[OFF_W-1:0];
    assign spr = exe_q.ins[F_SPR_HI:0];
    assign user = psw_q[PSW_U];

    rcial_regfile u_regs (
        .clk(clk),
        .ra_a(s1f),
        .ra_b(s2f),
        .rd_a(rs1),
        .rd_b(rs2),
        .we_x(fire && wr_en),
        .wa_x(wr_dst),
        .wd_x(res),
        .we_l(ld_pend_q),
        .wa_l(ld_dst_q),
        .wd_l(mem_rdata)
    );

    // Shared adders; overflow is judged on the sign bits.
    assign add_w = {1'b0, rs1} + {1'b0, rs2};
    assign sub_w = {1'b0, rs1} - {1'b0, rs2};
    assign addi_s = rs1 + sext_off(off);
    assign add_ovf = (rs1[XLEN-1] == rs2[XLEN-1]) && (add_w[XLEN-1] != rs1[XLEN-1]);
    assign sub_ovf = (rs1[XLEN-1] != rs2[XLEN-1]) && (sub_w[XLEN-1] != rs1[XLEN-1]);
    assign addi_ovf = (rs1[XLEN-1] == off[OFF_W-1]) && (addi_s[XLEN-1] != rs1[XLEN-1]);
    assign ms_w = md_q[0] ? add_w : {1'b0, rs1};
    assign dv = {rs1[XLEN-2:0], md_q[XLEN-1]};

    // Memory address: byte offset on the base, then the user-space force.
    // Vector bit 31 is big-endian bit 0, the space select bit.
    assign addr_raw = rs1 + sext_off(off);
    always_comb begin
        addr_eff = addr_raw;
        if (user) begin
            addr_eff[XLEN-1] = 1'b1;
        end
    end

    // The displacement adder runs beside the ALU; displacements count words.
    assign br_tgt = exe_q.pc + {{(WA_W-DISP_W){exe_q.ins[DISP_W-1]}},
                                exe_q.ins[DISP_W-1:0]};

    // Execute-stage operation decode.
    always_comb begin
        res = '0;
        wr_en = 1'b0;
        wr_dst = s2f;
        ovf = 1'b0;
        md_we = 1'b0;
        md_d = md_q;
        taken = 1'b0;
        is_br = 1'b0;
        jump = 1'b0;
        jump_pc = epc_q;
        psw_wr = 1'b0;
        pswo_wr = 1'b0;
        epc_wr = 1'b0;
        restore = 1'b0;
        trap_ins = 1'b0;
        unique case (cls)
            CLS_MEM: begin
                wr_en = 1'b0;
            end
            CLS_BR: begin
                is_br = 1'b1;
                case (op)
                    BC_EQ: taken = (rs1 == rs2);
                    BC_NE: taken = (rs1 != rs2);
                    BC_GE: taken = ($signed(rs1) >= $signed(rs2));
                    BC_LT: taken = ($signed(rs1) < $signed(rs2));
                    BC_HS: taken = (rs1 >= rs2);
                    BC_LO: taken = (rs1 < rs2);
                    default: is_br = 1'b0;
                endcase
            end
            CLS_CMP: begin
                wr_en = 1'b1;
                wr_dst = dsf;
                case (fn)
                    FN_ADD: begin
                        res = add_w[XLEN-1:0];
                        ovf = add_ovf;
                    end
                    FN_SUB: begin
                        res = sub_w[XLEN-1:0];
                        ovf = sub_ovf;
                    end
                    FN_SUBNC: res = rs1 + ~rs2;
                    FN_AND: res = rs1 & rs2;
                    FN_BIC: res = rs1 & ~rs2;
                    FN_NOT: res = ~rs1;
                    FN_OR: res = rs1 | rs2;
                    FN_XOR: res = rs1 ^ rs2;
                    FN_ASR: res = $signed(rs1) >>> shn;
                    FN_ROTLB: res = rotl_bytes(rs1, rs2[1:0]);
                    FN_ROTLCB: res = rotl_bytes(rs1, ~rs2[1:0]);
                    FN_SH: res = funnel(rs1, rs2, shn);
                    FN_DSTEP: begin
                        md_we = 1'b1;
                        res = (dv >= rs2) ? dv - rs2 : dv;
                        md_d = {md_q[XLEN-2:0], (dv >= rs2)};
                    end
                    FN_MSTART: begin
                        md_we = 1'b1;
                        md_d = rs2;
                    end
                    FN_MSTEP: begin
                        md_we = 1'b1;
                        res = ms_w[XLEN:1];
                        md_d = {ms_w[0], md_q[XLEN-1:1]};
                    end
                    default: wr_en = 1'b0;
                endcase
            end
            CLS_IMM: begin
                unique case (op)
                    IOP_ADDI: begin
                        wr_en = 1'b1;
                        res = addi_s;
                        ovf = addi_ovf;
                    end
                    IOP_JPC: jump = 1'b1;
                    IOP_JPCRS: begin
                        jump = 1'b1;
                        restore = 1'b1;
                    end
                    IOP_JSPCI: begin
                        wr_en = 1'b1;
                        res = {2'h0, exe_q.pc + PC_STEP};
                        jump = 1'b1;
                        jump_pc = addi_s[WA_W-1:0];
                    end
                    IOP_MFS: begin
                        wr_en = 1'b1;
                        unique case (spr)
                            SPR_PSW: res = {{(XLEN-PSW_W){1'b0}}, psw_q};
                            SPR_PSWO: res = {{(XLEN-PSW_W){1'b0}}, psw_o_q};
                            SPR_MD: res = md_q;
                            SPR_EPC: res = {2'h0, epc_q};
                        endcase
                    end
                    IOP_MTS: begin
                        unique case (spr)
                            SPR_PSW: psw_wr = ~user;
                            SPR_PSWO: pswo_wr = ~user;
                            SPR_MD: begin
                                md_we = 1'b1;
                                md_d = rs1;
                            end
                            SPR_EPC: epc_wr = 1'b1;
                        endcase
                    end
                    IOP_TRAP: trap_ins = 1'b1;
                    IOP_ALUC: wr_en = 1'b0;
                endcase
            end
        endcase
    end

    // Exception decision; the faulting instruction commits nothing.
    assign irq_take = exe_q.valid && (nmi_pend_q || (irq_s2_q && !psw_q[PSW_M]));
    assign exc = irq_take || (exe_q.valid && ((ovf && !psw_q[PSW_V]) || trap_ins));
    assign fire = exe_q.valid && !exc;
    assign squash = fire && is_br && exe_q.ins[F_SQ] && !taken;
    assign redirect = fire && ((is_br && taken) || jump);
    assign kill_now = exc || squash;

    // Fetch sequencing. The redirect lands after the two slots already fetched.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fetch_pc_q <= RESET_PC;
            if_pc_q <= RESET_PC;
        end else begin
            if_pc_q <= fetch_pc_q;
            if (exc) begin
                fetch_pc_q <= (trap_ins && !irq_take) ? {{(WA_W-OFF_W){1'b0}}, off} : EXC_VEC;
            end else if (redirect) begin
                fetch_pc_q <= jump ? jump_pc : br_tgt;
            end else begin
                fetch_pc_q <= fetch_pc_q + PC_STEP;
            end
        end
    end

    // Execute stage entry; a kill covers the arriving word and the next one.
    // After reset the first arriving word matches no fetch, so it is dropped.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            exe_q <= '0;
            kill_q <= 1'b1;
        end else begin
            kill_q <= kill_now;
            exe_q.valid <= !(kill_now || kill_q);
            exe_q.pc <= if_pc_q;
            exe_q.ins <= instr_in;
        end
    end

    // Interrupt pins pass two flops; the nonmaskable edge is held until taken.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
            nmi_s3_q <= 1'b0;
            nmi_pend_q <= 1'b0;
        end else begin
            irq_s1_q <= irq_req;
            irq_s2_q <= irq_s1_q;
            nmi_s1_q <= nmi_req;
            nmi_s2_q <= nmi_s1_q;
            nmi_s3_q <= nmi_s2_q;
            if (nmi_s2_q && !nmi_s3_q) begin
                nmi_pend_q <= 1'b1;
            end else if (irq_take) begin
                nmi_pend_q <= 1'b0;
            end
        end
    end

    // State word: exceptions save and enter system mode; return restores.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            psw_q <= PSW_RST;
            psw_o_q <= PSW_RST;
        end else if (exc) begin
            psw_o_q <= psw_q;
            psw_q[PSW_M] <= 1'b1;
            psw_q[PSW_U] <= 1'b0;
            psw_q[PSW_V] <= 1'b1;
            psw_q[PSW_I] <= !irq_take;
        end else if (fire) begin
            if (restore) begin
                psw_q <= psw_o_q;
            end else if (psw_wr) begin
                psw_q <= rs1[PSW_W-1:0];
            end
            if (pswo_wr) begin
                psw_o_q <= rs1[PSW_W-1:0];
            end
        end
    end

    // Restart point: the faulting instruction, or the one after a trap.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            epc_q <= RESET_PC;
        end else if (exc) begin
            epc_q <= trap_ins && !irq_take ? exe_q.pc + PC_STEP : exe_q.pc;
        end else if (fire && epc_wr) begin
            epc_q <= rs1[WA_W-1:0];
        end
    end

    // Multiply/divide step register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            md_q <= '0;
        end else if (fire && md_we) begin
            md_q <= md_d;
        end
    end

    // Memory requests, registered; only word address bits leave the core.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_req_q <= '0;
        end else begin
            mem_req_q <= '0;
            if (fire && cls == CLS_MEM) begin
                mem_req_q.addr <= addr_eff[XLEN-1:XLEN-WA_W];
                mem_req_q.wdata <= rs2;
                mem_req_q.rd <= !op[0];
                mem_req_q.wr <= op[0];
                mem_req_q.uncached <= (op == MOP_LDT) || (op == MOP_STT);
                if (op == MOP_LDF || op == MOP_STF) begin
                    mem_req_q.fp <= 1'b1;
                    mem_req_q.fp_register_select_lines <= s2f;
                end
                if (op == MOP_MFC || op == MOP_MTC) begin
                    mem_req_q.cop <= 1'b1;
                    mem_req_q.addr <= {{(WA_W-OFF_W){1'b0}}, off};
                end
            end else if (fire && cls == CLS_IMM && op == IOP_ALUC) begin
                mem_req_q.cop_alu <= 1'b1;
                mem_req_q.addr <= {{(WA_W-OFF_W){1'b0}}, off};
            end
        end
    end

    // Load data returns in the cycle the request is shown and lands at the end of that cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ld_pend_q <= 1'b0;
            ld_dst_q <= R0;
            exc_taken_q <= 1'b0;
        end else begin
            ld_pend_q <= fire && cls == CLS_MEM &&
                         (op == MOP_LD || op == MOP_LDT || op == MOP_MFC);
            ld_dst_q <= s2f;
            exc_taken_q <= exc;
        end
    end
endmodule : rcial_core

//--- design/rcial_pkg.sv
// Purpose: Shared constants and types for the integer core decode and address logic.
// Assumes: Little-endian vector indices; big-endian bit k of a word is vector bit 31-k.
// Notes: Opcode encodings and field positions below are local to this design.
package rcial_pkg;
    localparam int XLEN = 32;
    localparam int WA_W = 30;
    localparam int RS_W = 5;
    localparam int OFF_W = 17;
    localparam int DISP_W = 16;
    localparam int PSW_W = 4;
    // Instruction field positions.
    localparam int F_CLS_HI = 31;
    localparam int F_CLS_LO = 30;
    localparam int F_OP_HI = 29;
    localparam int F_OP_LO = 27;
    localparam int F_S1_HI = 26;
    localparam int F_S1_LO = 22;
    localparam int F_S2_HI = 21;
    localparam int F_S2_LO = 17;
    localparam int F_DS_HI = 16;
    localparam int F_DS_LO = 12;
    localparam int F_FN_HI = 11;
    localparam int F_FN_LO = 8;
    localparam int F_SH_HI = 4;
    localparam int F_SQ = 16;
    localparam int F_SPR_HI = 1;
    // Instruction classes.
    typedef enum logic [1:0] {
        CLS_MEM = 2'b00,
        CLS_BR = 2'b01,
        CLS_CMP = 2'b10,
        CLS_IMM = 2'b11
    } rcial_class_t;
    // Memory-format operations.
    localparam logic [2:0] MOP_LD = 3'h0, MOP_ST = 3'h1, MOP_LDF = 3'h2, MOP_STF = 3'h3;
    localparam logic [2:0] MOP_LDT = 3'h4, MOP_STT = 3'h5, MOP_MFC = 3'h6, MOP_MTC = 3'h7;
    // Branch conditions; codes 6 and 7 are illegal.
    localparam logic [2:0] BC_EQ = 3'h0, BC_NE = 3'h1, BC_GE = 3'h2, BC_LT = 3'h3;
    localparam logic [2:0] BC_HS = 3'h4, BC_LO = 3'h5;
    // Compute functions; code f is illegal.
    localparam logic [3:0] FN_ADD = 4'h0, FN_SUB = 4'h1, FN_SUBNC = 4'h2, FN_AND = 4'h3;
    localparam logic [3:0] FN_BIC = 4'h4, FN_NOT = 4'h5, FN_OR = 4'h6, FN_XOR = 4'h7;
    localparam logic [3:0] FN_ASR = 4'h8, FN_ROTLB = 4'h9, FN_ROTLCB = 4'ha, FN_SH = 4'hb;
    localparam logic [3:0] FN_DSTEP = 4'hc, FN_MSTART = 4'hd, FN_MSTEP = 4'he;
    // Compute-immediate operations.
    localparam logic [2:0] IOP_ADDI = 3'h0, IOP_JPC = 3'h1, IOP_JPCRS = 3'h2, IOP_JSPCI = 3'h3;
    localparam logic [2:0] IOP_MFS = 3'h4, IOP_MTS = 3'h5, IOP_TRAP = 3'h6, IOP_ALUC = 3'h7;
    // Special registers.
    localparam logic [1:0] SPR_PSW = 2'h0, SPR_PSWO = 2'h1, SPR_MD = 2'h2, SPR_EPC = 2'h3;
    // State word bits: interrupt mask, user mode, overflow mask, not-interrupt flag.
    localparam int PSW_M = 0;
    localparam int PSW_U = 1;
    localparam int PSW_V = 2;
    localparam int PSW_I = 3;
    localparam logic [PSW_W-1:0] PSW_RST = 4'h9;
    localparam logic [WA_W-1:0] RESET_PC = 30'h0;
    localparam logic [WA_W-1:0] EXC_VEC = 30'h1;
    localparam logic [RS_W-1:0] R0 = 5'h0;
    localparam logic [WA_W-1:0] PC_STEP = 30'h1;

    typedef struct packed {
        logic rd;
        logic wr;
        logic uncached;
        logic cop;
        logic cop_alu;
        logic fp;
        logic [RS_W-1:0] fp_register_select_lines;
        logic [WA_W-1:0] addr;
        logic [XLEN-1:0] wdata;
    } rcial_mem_req_t;

    typedef struct packed {
        logic valid;
        logic [WA_W-1:0] pc;
        logic [XLEN-1:0] ins;
    } rcial_stage_t;
endpackage : rcial_pkg

//--- design/rcial_regfile.sv
// Purpose: Thirty-two word register file with two reads and two writes.
// Assumes: Writes land at the clock edge; reads are combinational.
// Notes: Register zero is never stored and always reads as zero.
`timescale 1ns/1ns
module rcial_regfile
    import rcial_pkg::*;
(
    input wire logic clk,
    input wire logic [RS_W-1:0] ra_a,
    input wire logic [RS_W-1:0] ra_b,
    output logic [XLEN-1:0] rd_a,
    output logic [XLEN-1:0] rd_b,
    input wire logic we_x,
    input wire logic [RS_W-1:0] wa_x,
    input wire logic [XLEN-1:0] wd_x,
    input wire logic we_l,
    input wire logic [RS_W-1:0] wa_l,
    input wire logic [XLEN-1:0] wd_l
);
    logic [XLEN-1:0] mem [0:XLEN-1];

    // Late load data first, so an execute write to the same register wins.
    always_ff @(posedge clk) begin
        if (we_l && wa_l != R0) begin
            mem[wa_l] <= wd_l;
        end
        if (we_x && wa_x != R0) begin
            mem[wa_x] <= wd_x;
        end
    end

    // Reads of register zero bypass the array.
    assign rd_a = (ra_a == R0) ? '0 : mem[ra_a];
    assign rd_b = (ra_b == R0) ? '0 : mem[ra_b];
endmodule : rcial_regfile

//--- test/rcial_monitor.sv
// Purpose: Port-level checks on the integer core.
// Assumes: One clock; nrst is asynchronous and active low.
// Notes: Bound to every core instance; sees outputs and the nonmaskable interrupt input only.
`timescale 1ns/1ns
module rcial_monitor
    import rcial_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic nmi_req,
    input wire logic [WA_W-1:0] fetch_pc_q,
    input wire rcial_mem_req_t mem_req_q,
    input wire logic [PSW_W-1:0] psw_q,
    input wire logic exc_taken_q
);
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic xfer;
    // A data-port transfer is any read or write strobe.
    assign xfer = mem_req_q.rd | mem_req_q.wr;
    // After release the fetch address leaves word zero on exactly the next edge.
    sequence s_boot;
        fetch_pc_q == RESET_PC ##1 fetch_pc_q == PC_STEP;
    endsequence
    chk_boot_fetch: assert property ($rose(nrst) |-> s_boot)
        else $error("fetch did not step from word zero after reset");
    chk_reset_state: assert property ($rose(nrst) |-> psw_q == PSW_RST && !xfer)
        else $error("state word or port wrong at reset release");
    chk_idle_quiet: assert property (!xfer && !mem_req_q.cop_alu |-> mem_req_q == '0)
        else $error("data port not quiet between transfers");
    chk_fp_select: assert property (mem_req_q.fp |-> xfer && !mem_req_q.cop)
        else $error("fp select shown without a memory transfer");
    chk_cop_field: assert property (mem_req_q.cop && xfer |->
        mem_req_q.addr[WA_W-1:OFF_W] == '0)
        else $error("coprocessor field wider than the offset");
    // The $past term keeps a mode change in flight from tripping the check.
    chk_user_force: assert property (xfer && !mem_req_q.cop && psw_q[PSW_U] &&
        $past(psw_q[PSW_U]) |-> mem_req_q.addr[WA_W-1])
        else $error("user mode access reached system space");
    chk_exc_state: assert property (exc_taken_q |->
        !psw_q[PSW_U] && psw_q[PSW_M] && psw_q[PSW_V])
        else $error("exception left wrong state word");
    chk_nmi_taken: assert property ($rose(nmi_req) |-> ##[1:12] exc_taken_q)
        else $error("nonmaskable interrupt not taken in time");
endmodule : rcial_monitor
bind rcial_core rcial_monitor u_mon (.clk, .nrst, .nmi_req, .fetch_pc_q, .mem_req_q, .psw_q,
    .exc_taken_q);

//--- test/rcial_mem_model.sv
// Purpose: Word memory standing on the core's data port.
// Assumes: Reads are answered in the cycle the request is shown.
// Notes: Sixteen words aliased on the low address bits.
`timescale 1ns/1ns
module rcial_mem_model
    import rcial_pkg::*;
(
    input wire logic clk,
    input wire rcial_mem_req_t req,
    output logic [XLEN-1:0] rdata
);
    logic [XLEN-1:0] mem [0:15];
    logic [XLEN-1:0] junk_q = 32'h0;
    // Outside a read the bus toggles, so a stale sample can never pass.
    assign rdata = req.rd ? mem[req.addr[3:0]] : junk_q;
    // Only whole words are stored; coprocessor traffic is decoded elsewhere.
    always @(posedge clk) begin
        junk_q <= ~junk_q;
        if (req.wr && !req.cop && !req.fp) mem[req.addr[3:0]] <= req.wdata;
    end
    initial for (int i = 0; i < 16; i++) mem[i] = 32'h5a00_0000 + i;
endmodule : rcial_mem_model

//--- test/tb_top.sv
// Purpose: Directed run of the integer core against a small word memory.
// Assumes: Words come from a table indexed by the previous fetch address.
// Notes: Registers are built with add-immediate, since the file is not reset.
`timescale 1ns/1ns
module tb_top;
    import rcial_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic nmi_req = 1'b0;
    logic irq_req = 1'b0;
    logic [XLEN-1:0] instr_in = 32'h8000_0000;
    logic [XLEN-1:0] mem_rdata;
    logic [WA_W-1:0] fetch_pc_q;
    rcial_mem_req_t mem_req_q;
    logic [PSW_W-1:0] psw_q;
    logic exc_taken_q;
    logic [XLEN-1:0] prog [0:63];
    rcial_mem_req_t log_q[$];
    int mismatches = 0;
    int tests_run = 0;
    rcial_core DUT (.clk, .nrst, .instr_in, .mem_rdata, .irq_req, .nmi_req,
        .fetch_pc_q, .mem_req_q, .psw_q, .exc_taken_q);
    rcial_mem_model u_mem (.clk, .req(mem_req_q), .rdata(mem_rdata));
    // Free-running clock, 50 ns period.
    initial forever #25 clk = ~clk;
    // Present the word for last cycle's fetch address.
    always @(posedge clk) instr_in <= prog[fetch_pc_q[5:0]];
    // Record every transfer; stores are spaced by a nop as the cache needs.
    always @(posedge clk) if (mem_req_q.rd | mem_req_q.wr) log_q.push_back(mem_req_q);
    function automatic logic [31:0] enc(logic [1:0] c, logic [2:0] op, logic [4:0] a,
        logic [4:0] b, logic [16:0] off);
        return {c, op, a, b, off};
    endfunction : enc
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic t_memops;
        logic [4:0] fl [9] = '{5'h08, 5'h14, 5'h09, 5'h0a, 5'h0c, 5'h08, 5'h08, 5'h08, 5'h08};
        logic [29:0] ad [9] = '{30'h2, 30'h7, 30'h48e, 30'h1abcd, 30'h0, 30'h8, 30'h2000_0002,
            30'h2000_0003, 30'h2000_0006};
        logic [31:0] wd [9] = '{32'h1234, 32'h0, 32'h0, 32'h1234, 32'h5a00_0007, 32'h0, 32'h1234,
            32'h1234, 32'h1234};
        rcial_mem_req_t g;
        for (int w = 0; w < 80 && log_q.size() < 9; w++) @(posedge clk);
        check(32'(log_q.size()), 32'h9);
        for (int i = 0; i < 9 && i < log_q.size(); i++) begin
            g = log_q[i];
            check(32'({g.rd, g.wr, g.uncached, g.cop, g.fp}), 32'(fl[i]));
            check(32'(g.addr), 32'(ad[i]));
            if (fl[i][3] && !fl[i][0]) check(g.wdata, wd[i]);
            if (fl[i][0]) check(32'(g.fp_register_select_lines), 32'h5);
        end
        $display("memory operations done");
    endtask : t_memops
    task automatic t_user;
        irq_req <= 1'b1;
        repeat (8) @(posedge clk);
        check(32'(psw_q), 32'hb);
        irq_req <= 1'b0;
        $display("user mode done");
    endtask : t_user
    task automatic t_nmi;
        nmi_req <= 1'b1;
        for (int w = 0; w < 20 && exc_taken_q !== 1'b1; w++) @(posedge clk);
        check(32'(exc_taken_q), 32'h1);
        check(32'(psw_q), 32'h5);
        nmi_req <= 1'b0;
        $display("interrupt done");
    endtask : t_nmi
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // Program: values, then store, uncached, fp, coprocessor, user-mode and branch traffic.
    initial begin
        for (int i = 0; i < 64; i++) prog[i] = 32'h8000_0000;
        prog[0] = enc(CLS_IMM, IOP_ADDI, 5'h0, 5'h1, 17'h1fff8);
        prog[1] = enc(CLS_IMM, IOP_ADDI, 5'h0, 5'h2, 17'h01234);
        prog[2] = enc(CLS_MEM, MOP_ST, 5'h1, 5'h2, 17'h00010);
        prog[4] = enc(CLS_MEM, MOP_LDT, 5'h0, 5'h3, 17'h0001c);
        prog[6] = enc(CLS_MEM, MOP_STF, 5'h2, 5'h5, 17'h00004);
        prog[8] = enc(CLS_MEM, MOP_MTC, 5'h0, 5'h2, 17'h1abcd);
        prog[10] = enc(CLS_MEM, MOP_STT, 5'h0, 5'h3, 17'h00000);
        prog[12] = enc(CLS_IMM, IOP_ADDI, 5'h0, 5'h0, 17'h00005);
        prog[13] = enc(CLS_MEM, MOP_ST, 5'h0, 5'h0, 17'h00020);
        prog[15] = enc(CLS_IMM, IOP_ADDI, 5'h0, 5'h4, 17'h0000b);
        prog[16] = enc(CLS_IMM, IOP_MTS, 5'h4, 5'h0, 17'h00000);
        prog[18] = enc(CLS_MEM, MOP_ST, 5'h0, 5'h2, 17'h00008);
        prog[20] = enc(CLS_IMM, IOP_MTS, 5'h0, 5'h0, 17'h00000);
        prog[22] = enc(CLS_BR, BC_NE, 5'h0, 5'h2, 17'h10004);
        prog[23] = enc(CLS_MEM, MOP_ST, 5'h0, 5'h2, 17'h0000c);
        prog[25] = enc(CLS_MEM, MOP_ST, 5'h0, 5'h2, 17'h00010);
        prog[26] = enc(CLS_BR, BC_EQ, 5'h0, 5'h2, 17'h10004);
        prog[27] = enc(CLS_MEM, MOP_ST, 5'h0, 5'h2, 17'h00014);
        prog[29] = enc(CLS_MEM, MOP_ST, 5'h0, 5'h2, 17'h00018);
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_memops();
        t_user();
        t_nmi();
        end_of_test();
    end
    // Watchdog: the tests need about 50 cycles.
    initial begin
        repeat (400) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule : tb_top
